// file: core/lat_pkg.sv
// Shared constants and carriers for the learned address table readout.
// Assumes an 8-bit indirect register space and a 10-bit table index.
package lat_pkg;

  // Indirect register numbers
  localparam logic [7:0] REG_CTRL       = 8'h6e;  // Select code and index high bits
  localparam logic [7:0] REG_INDEX      = 8'h6f;  // Index low byte, write triggers
  localparam logic [7:0] REG_DATA_FIRST = 8'h70;  // Entry bits 71..64
  localparam logic [7:0] REG_DATA_LAST  = 8'h78;  // Entry bits 7..0

  // Control register layout
  localparam int         CTRL_READ_BIT  = 4;
  localparam int         CTRL_SEL_LSB   = 2;
  localparam logic [1:0] SEL_DYNAMIC    = 2'h2;   // Learned table select
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] INDEX_RESET    = 8'h00;

  // Table geometry
  localparam int IDX_W      = 10;
  localparam int COUNT_W    = 10;
  localparam int TOTAL_W    = 11;
  localparam int ENTRY_W    = 72;
  localparam int DATA_BYTES = 9;

  // One learned entry, bit 71 down to bit 0
  typedef struct packed {
    logic        table_empty_flag;   // 71
    logic [9:0]  valid_entry_count;  // 70..61
    logic [1:0]  age_stamp;          // 60..59
    logic [2:0]  source_port;        // 58..56
    logic        not_ready;          // 55
    logic [6:0]  filter_group_id;    // 54..48
    logic [47:0] mac_addr;           // 47..0
  } lat_entry_t;

  // Host register access, one cycle strobes
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lat_host_req_t;

  // Answer from the table lookup engine
  typedef struct packed {
    logic        ack;
    logic [1:0]  age_stamp;
    logic [2:0]  source_port;
    logic [6:0]  filter_group_id;
    logic [47:0] mac_addr;
  } lat_tbl_rsp_t;

  // Reset image of the data registers: table empty, nothing fetched
  localparam lat_entry_t ENTRY_RESET = '{
    table_empty_flag:  1'b1,
    valid_entry_count: 10'h000,
    age_stamp:         2'h0,
    source_port:       3'h0,
    not_ready:         1'b0,
    filter_group_id:   7'h00,
    mac_addr:          48'h0000_0000_0000
  };

endpackage

// file: core/lat_entry_hold.sv
// Data register image of one fetched entry, with byte readout.
// Assumes the owner sequences start and finish of each fetch.
`timescale 1ns/10ps
`default_nettype none

module lat_entry_hold (
  // Clock and reset
  input  wire logic               mclk_i,
  input  wire logic               reset_i,
  // Fetch start: occupancy captured, entry marked not ready
  input  wire logic               start_i,
  input  wire logic               empty_i,
  input  wire logic [9:0]         count_i,
  // Fetch finish: entry fields from the table engine
  input  wire logic               done_i,
  input  wire lat_pkg::lat_tbl_rsp_t rsp_i,
  // Readout
  input  wire logic [3:0]         byte_sel_i,
  output logic [7:0]              byte_o,
  output var lat_pkg::lat_entry_t entry_o
);

  lat_pkg::lat_entry_t entry_reg;
  lat_pkg::lat_entry_t entry_next;
  logic [lat_pkg::ENTRY_W-1:0] flat;

  // Next image: start wins over finish, otherwise hold
  always_comb begin
    entry_next = entry_reg;
    if (start_i) begin
      entry_next.table_empty_flag  = empty_i;
      entry_next.valid_entry_count = count_i;
      entry_next.not_ready         = 1'b1;
    end else if (done_i) begin
      entry_next.age_stamp       = rsp_i.age_stamp;
      entry_next.source_port     = rsp_i.source_port;
      entry_next.filter_group_id = rsp_i.filter_group_id;
      entry_next.mac_addr        = rsp_i.mac_addr;
      entry_next.not_ready       = 1'b0;
    end
  end

  // Register the image
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      entry_reg <= lat_pkg::ENTRY_RESET;
    end else begin
      entry_reg <= entry_next;
    end
  end

  // Byte 0 is bits 71..64, byte 8 is bits 7..0
  assign flat    = entry_reg;
  assign entry_o = entry_reg;

  always_comb begin
    byte_o = 8'h00;
    for (int i = 0; i < lat_pkg::DATA_BYTES; i++) begin
      if (byte_sel_i == 4'(i)) begin
        byte_o = flat[lat_pkg::ENTRY_W-1-8*i -: 8];
      end
    end
  end

endmodule

`default_nettype wire

// file: core/lat_readout.sv
// Learned address table readout: indirect control, fetch and data registers.
// Assumes host strobes and table engine signals run on mclk_i.
`timescale 1ns/10ps
`default_nettype none

module lat_readout #(
  parameter int IDX_W = lat_pkg::IDX_W
) (
  // Clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  reset_i,
  // Host indirect register access
  input  wire lat_pkg::lat_host_req_t host_i,
  output logic [7:0]                 rdata_o,
  output logic                       rvalid_o,
  // Table lookup engine, read only
  output logic                       tbl_req_o,
  output logic [IDX_W-1:0]           tbl_index_o,
  input  wire lat_pkg::lat_tbl_rsp_t tbl_rsp_i,
  input  wire logic [10:0]           valid_total_i,
  // Status
  output logic                       fetch_busy_o
);

  typedef enum logic {LAT_IDLE, LAT_FETCH} lat_state_t;

  lat_state_t          state_reg, state_next;
  logic [7:0]          ctrl_reg, ctrl_next;
  logic [7:0]          index_reg, index_next;
  logic                req_reg, req_next;
  logic [IDX_W-1:0]    tidx_reg, tidx_next;
  logic [7:0]          rdata_reg, rdata_next;
  logic                rvalid_reg, rvalid_next;
  logic                trigger;
  logic                done;
  logic                occ_empty;
  logic [9:0]          occ_count;
  logic [3:0]          byte_sel;
  logic [7:0]          data_byte;
  lat_pkg::lat_entry_t entry;

  // Trigger: index write while control selects learned table read
  assign trigger = host_i.wr && (host_i.addr == lat_pkg::REG_INDEX)
                 && ctrl_reg[lat_pkg::CTRL_READ_BIT]
                 && (ctrl_reg[lat_pkg::CTRL_SEL_LSB +: 2] == lat_pkg::SEL_DYNAMIC);
  assign done    = (state_reg == LAT_FETCH) && tbl_rsp_i.ack && !trigger;

  // Occupancy encoding: count minus one, zero when empty
  assign occ_empty = (valid_total_i == 11'h000);
  assign occ_count = occ_empty ? 10'h000 : 10'(valid_total_i - 11'h001);

  // Byte lane of the data register being read
  assign byte_sel = 4'(host_i.addr - lat_pkg::REG_DATA_FIRST);

  lat_entry_hold u_hold (
    .mclk_i     (mclk_i),
    .reset_i    (reset_i),
    .start_i    (trigger),
    .empty_i    (occ_empty),
    .count_i    (occ_count),
    .done_i     (done),
    .rsp_i      (tbl_rsp_i),
    .byte_sel_i (byte_sel),
    .byte_o     (data_byte),
    .entry_o    (entry)
  );

  // Control and index registers, fetch sequencing
  always_comb begin
    ctrl_next  = ctrl_reg;
    index_next = index_reg;
    state_next = state_reg;
    req_next   = req_reg;
    tidx_next  = tidx_reg;
    if (host_i.wr && host_i.addr == lat_pkg::REG_CTRL) begin
      ctrl_next = host_i.wdata;
    end
    if (host_i.wr && host_i.addr == lat_pkg::REG_INDEX) begin
      index_next = host_i.wdata;
    end
    case (state_reg)
      LAT_IDLE: begin
        if (trigger) begin
          state_next = LAT_FETCH;
          req_next   = 1'b1;
          tidx_next  = {ctrl_reg[1:0], host_i.wdata};
        end
      end
      LAT_FETCH: begin
        if (trigger) begin
          tidx_next = {ctrl_reg[1:0], host_i.wdata};
        end else if (tbl_rsp_i.ack) begin
          state_next = LAT_IDLE;
          req_next   = 1'b0;
        end
      end
      default: begin
        state_next = LAT_IDLE;
        req_next   = 1'b0;
      end
    endcase
  end

  // Read port; data registers have no write path into the table
  always_comb begin
    rdata_next  = 8'h00;
    rvalid_next = host_i.rd;
    if (host_i.rd) begin
      if (host_i.addr == lat_pkg::REG_CTRL) begin
        rdata_next = ctrl_reg;
      end else if (host_i.addr == lat_pkg::REG_INDEX) begin
        rdata_next = index_reg;
      end else if (host_i.addr >= lat_pkg::REG_DATA_FIRST
                   && host_i.addr <= lat_pkg::REG_DATA_LAST) begin
        rdata_next = data_byte;
      end
    end
  end

  // Register all state
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_reg  <= LAT_IDLE;
      ctrl_reg   <= lat_pkg::CTRL_RESET;
      index_reg  <= lat_pkg::INDEX_RESET;
      req_reg    <= 1'b0;
      tidx_reg   <= '0;
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      ctrl_reg   <= ctrl_next;
      index_reg  <= index_next;
      req_reg    <= req_next;
      tidx_reg   <= tidx_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign rdata_o      = rdata_reg;
  assign rvalid_o     = rvalid_reg;
  assign tbl_req_o    = req_reg;
  assign tbl_index_o  = tidx_reg;
  assign fetch_busy_o = req_reg;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  trigger_starts_fetch_a: assert property (
    trigger |=> tbl_req_o && state_reg == LAT_FETCH)
    else $error("trigger did not start a fetch");

  index_split_a: assert property (
    trigger |=> tbl_index_o == {$past(ctrl_reg[1:0]), $past(host_i.wdata)})
    else $error("fetch index not built from both registers");

  busy_flag_a: assert property (
    state_reg == LAT_FETCH |-> entry.not_ready)
    else $error("ready flag clear during fetch");

  ack_clears_flag_a: assert property (
    done |=> !entry.not_ready && !tbl_req_o)
    else $error("ready flag not cleared after answer");

  occupancy_capture_a: assert property (
    trigger |=> entry.valid_entry_count == $past(occ_count)
                && entry.table_empty_flag == ($past(valid_total_i) == 11'h000))
    else $error("occupancy not captured at trigger");

  data_hold_a: assert property (
    state_reg == LAT_IDLE && !trigger |=> $stable(entry))
    else $error("data registers moved without trigger");

  top_byte_read_a: assert property (
    host_i.rd && host_i.addr == lat_pkg::REG_DATA_FIRST
    |=> rvalid_o && rdata_o == {$past(entry.table_empty_flag),
                                $past(entry.valid_entry_count[9:3])})
    else $error("register 112 readout wrong");

  mac_high_read_a: assert property (
    host_i.rd && host_i.addr == 8'h73 |=> rdata_o == $past(entry.mac_addr[47:40]))
    else $error("register 115 readout wrong");

  fid_read_a: assert property (
    host_i.rd && host_i.addr == 8'h72
    |=> rdata_o == {$past(entry.not_ready), $past(entry.filter_group_id)})
    else $error("register 114 readout wrong");

  req_held_a: assert property (
    tbl_req_o && !tbl_rsp_i.ack |=> tbl_req_o)
    else $error("request dropped before answer");

  // A new trigger mid fetch keeps the request up and the entry not ready
  restart_fetch_a: assert property (
    state_reg == LAT_FETCH && trigger |=> tbl_req_o && entry.not_ready)
    else $error("retrigger during fetch did not restart it");

  // Index writes without the learned table read select start nothing
  no_fetch_select_a: assert property (
    state_reg == LAT_IDLE && host_i.wr && host_i.addr == lat_pkg::REG_INDEX && !trigger
    |=> !tbl_req_o)
    else $error("fetch started without learned table select");

endmodule

`default_nettype wire

// file: tb/lat_engine_model.sv
// Table lookup engine model: answers each fetch after a set delay.
// Assumes the fetch request is a level held until the edge after ack.
`timescale 1ns/10ps
`default_nettype none

module lat_engine_model (
  // Clock and fetch link
  input  wire logic             mclk_i,
  input  wire logic             req_i,
  input  wire logic [9:0]       index_i,
  input  wire logic [7:0]       delay_i,
  output var lat_pkg::lat_tbl_rsp_t rsp_o
);
  logic [7:0]  cnt = 8'h00;
  logic        ack = 1'b0;
  logic [59:0] fields;

  // Delay count, one ack pulse per request
  always @(posedge mclk_i) begin
    if (!req_i || ack) begin
      cnt <= 8'h00;
      ack <= 1'b0;
    end else if (cnt == delay_i) begin
      ack <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  // Fields valid with ack only, inverted otherwise
  always_comb begin
    fields = {index_i[1:0], 3'(index_i % 10'd5), index_i[8:2], 38'h2a_5c3e_91b7, index_i};
    rsp_o  = {ack, ack ? fields : ~fields};
  end
endmodule

`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the learned address table readout.
// Assumes the engine model answers every fetch; host strobes at falling edge.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic                   mclk_i  = 1'b0;
  logic                   reset_i = 1'b1;
  lat_pkg::lat_host_req_t host    = '0;
  lat_pkg::lat_tbl_rsp_t  rsp;
  logic [10:0]            total   = 11'h000;
  logic [7:0]             delay   = 8'h02;
  logic [7:0]             rdata;
  logic                   rvalid;
  logic                   req;
  logic                   busy;
  logic [9:0]             index;
  int                     mismatches = 0;
  int                     num_checks = 0;

  // Clock, 5 ns period
  always #2.5 mclk_i = ~mclk_i;

  lat_readout u_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .host_i(host), .rdata_o(rdata),
    .rvalid_o(rvalid), .tbl_req_o(req), .tbl_index_o(index), .tbl_rsp_i(rsp),
    .valid_total_i(total), .fetch_busy_o(busy));

  lat_engine_model u_eng (
    .mclk_i(mclk_i), .req_i(req), .index_i(index), .delay_i(delay), .rsp_o(rsp));

  // Compare and count
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    host.wr    = 1'b1;
    host.addr  = a;
    host.wdata = d;
    @(negedge mclk_i);
    host.wr = 1'b0;
  endtask

  // One register read, answer taken one cycle later
  task automatic rd_raw(input logic [7:0] a, output logic [7:0] v);
    @(negedge mclk_i);
    host.rd   = 1'b1;
    host.addr = a;
    @(negedge mclk_i);
    host.rd = 1'b0;
    check("rvalid", rvalid, 10'h001);
    v = rdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd_raw(a, v);
    check($sformatf("reg %0d", a), v, exp);
  endtask

  task automatic fetch(input logic [7:0] c, input logic [7:0] l);
    wr(lat_pkg::REG_CTRL, c);
    wr(lat_pkg::REG_INDEX, l);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    @(negedge mclk_i);
    while (busy !== 1'b0 && n < 300) begin
      @(negedge mclk_i);
      n++;
    end
    check("busy", busy, 10'h000);
  endtask

  // Read all nine data registers against the expected entry
  task automatic rd_entry(input logic [9:0] idx, input logic [10:0] tot);
    lat_pkg::lat_entry_t e;
    logic [71:0]         b;
    e.table_empty_flag  = (tot == 11'h000);
    e.valid_entry_count = (tot == 11'h000) ? 10'h000 : 10'(tot - 11'h001);
    e.age_stamp         = idx[1:0];
    e.source_port       = 3'(idx % 10'd5);
    e.not_ready         = 1'b0;
    e.filter_group_id   = idx[8:2];
    e.mac_addr          = {38'h2a_5c3e_91b7, idx};
    b = e;
    for (int i = 0; i < 9; i++) begin
      rd(8'h70 + 8'(i), b[71-8*i -: 8]);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #100000;
    mismatches++;
    final_report;
  end

  // Main sequence
  initial begin
    logic [7:0] v;
    logic       seen_busy;
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    reset_i = 1'b0;
    rd(8'h70, 8'h80);
    rd(8'h72, 8'h00);
    // Full table, first entry
    total = 11'd1024;
    fetch(8'h18, 8'h00);
    wait_idle;
    rd_entry(10'h000, 11'd1024);
    // Entry 257, upper index bits in the control register
    total = 11'd2;
    fetch(8'h19, 8'h01);
    check("index", index, 10'h101);
    wait_idle;
    rd_entry(10'h101, 11'd2);
    rd(8'h6e, 8'h19);
    rd(8'h6f, 8'h01);
    // Slow engine on an empty table, host retries until ready
    delay     = 8'd40;
    total     = 11'h000;
    seen_busy = 1'b0;
    fetch(8'h18, 8'h05);
    for (int n = 0; n < 60; n++) begin
      rd_raw(8'h72, v);
      if (v[7] === 1'b0) break;
      seen_busy = 1'b1;
    end
    check("retry", seen_busy, 10'h001);
    rd_entry(10'h005, 11'h000);
    // Other table select, read bit clear and data writes leave the image alone
    fetch(8'h14, 8'h07);
    check("busy", busy, 10'h000);
    fetch(8'h08, 8'h07);
    check("busy", busy, 10'h000);
    wr(8'h73, 8'hff);
    rd_entry(10'h005, 11'h000);
    rd(8'h00, 8'h00);
    // Retrigger during a slow fetch: new index and occupancy win
    delay = 8'd20;
    total = 11'd3;
    fetch(8'h18, 8'h09);
    check("busy", busy, 10'h001);
    total = 11'd5;
    fetch(8'h1b, 8'h02);
    check("index", index, 10'h302);
    wait_idle;
    rd_entry(10'h302, 11'd5);
    // Reset in mid run returns the image to empty
    @(negedge mclk_i);
    reset_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    reset_i = 1'b0;
    rd(8'h70, 8'h80);
    rd(8'h72, 8'h00);
    rd(8'h6e, 8'h00);
    final_report;
  end
endmodule

`default_nettype wire
